// [rtl/ccs_defs.svh]
// Purpose: Constants for the capacitance conversion sequencer.
// Assumes: Included by bare name from the design files.
// Notes:   Offsets are register word addresses on the register port.
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ==========================================================================
// Register addresses
// ==========================================================================
`define CCS_CTRL_ADDR     10'h000
`define CCS_RAW_ADDR      10'h00B
`define CCS_OFFS_ADDR     10'h010
`define CCS_LAST_ADDR     10'h011
`define CCS_STATUS_ADDR   10'h012
`define CCS_RES_BASE      10'h0E0

// ==========================================================================
// Field positions, codes and reset values
// ==========================================================================
`define CCS_MODE_LSB      0
`define CCS_SLEEP_LSB     2
`define CCS_DECIM_LSB     8
`define CCS_OPOS_LSB      0
`define CCS_POS_SWAP_BIT  7
`define CCS_ONEG_LSB      8
`define CCS_NEG_SWAP_BIT  15
`define CCS_MODE_FULL     2'h0
`define CCS_MODE_LOW      2'h2
`define CCS_DECIM_256     2'h0
`define CCS_CTRL_RST      16'h0000
`define CCS_OFFS_RST      16'h0000
`define CCS_LAST_RST      4'hB
`define CCS_LAST_MAX      4'hB
`define CCS_NUM_STAGES    12

// ==========================================================================
// Timing
// ==========================================================================
`define CCS_CLOCK_MHZ      200
`define CCS_SAMPLE_KHZ     250
`define CCS_SAMPLE_DIV     ((`CCS_CLOCK_MHZ * 1000) / `CCS_SAMPLE_KHZ)
`define CCS_AVG_MULT       3
`define CCS_LEN_256        (`CCS_AVG_MULT * 256)
`define CCS_LEN_128        (`CCS_AVG_MULT * 128)
`define CCS_GAIN_256       85
`define CCS_GAIN_128       170
`define CCS_SLEEP_STEP_MS  200
`define CCS_TOUCH_MS       36
`define CCS_SLEEP_STEP_TICKS (`CCS_SLEEP_STEP_MS * `CCS_SAMPLE_KHZ)
`define CCS_TOUCH_TICKS    (`CCS_TOUCH_MS * `CCS_SAMPLE_KHZ)

`endif

// [rtl/ccs_filter.sv]
// Purpose: Averaging decimation filter for one stage conversion.
// Assumes: Sample enables arrive at the modulator rate.
// Notes:   The average is scaled to the full 16-bit range by a fixed gain.
`timescale 1ns/1ps
`include "ccs_defs.svh"
module ccs_filter
  import ccs_pkg::*;
(
  input  wire logic CLOCK,
  input  wire logic RESET_N,
  ccs_if.filt       ifc
);
  // ========================================================================
  // State
  // ========================================================================
  logic [9:0]   cnt_reg, cnt_next;   // Samples taken so far.
  logic [9:0]   sum_reg, sum_next;   // Ones counted so far.
  ccs_word_type res_reg, res_next;   // Last result.
  logic         done_reg, done_next; // Result strobe.
  logic [9:0]   limit;               // Last sample index of the stage.
  logic [9:0]   sum_inc;             // Sum including this sample.
  logic [15:0]  gain;                // Scale to 16 bits.

  // Sample count is three times the ratio; the gain keeps full scale.
  always_comb begin
    limit    = (ifc.decim == `CCS_DECIM_256) ? 10'(`CCS_LEN_256 - 1)
                                             : 10'(`CCS_LEN_128 - 1); // see (R01) (R03)
    gain     = (ifc.decim == `CCS_DECIM_256) ? 16'(`CCS_GAIN_256) : 16'(`CCS_GAIN_128);
    sum_inc  = sum_reg + {9'h000, ifc.mod_bit};
    cnt_next = cnt_reg;
    sum_next = sum_reg;
    res_next = res_reg;
    done_next = 1'b0;
    if (!ifc.run) begin
      // An aborted stage leaves nothing half counted.
      cnt_next = 10'h000;
      sum_next = 10'h000;
    end else if (ifc.sample_en) begin
      if (cnt_reg == limit) begin
        res_next  = 16'({6'h00, sum_inc} * gain); // see (R03) (R05)
        done_next = 1'b1;
        cnt_next  = 10'h000;
        sum_next  = 10'h000;
      end else begin
        cnt_next = cnt_reg + 10'h001;
        sum_next = sum_inc;
      end
    end
  end

  // Registers only.
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      cnt_reg  <= 10'h000;
      sum_reg  <= 10'h000;
      res_reg  <= 16'h0000;
      done_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      sum_reg  <= sum_next;
      res_reg  <= res_next;
      done_reg <= done_next;
    end
  end

  assign ifc.done   = done_reg;
  assign ifc.result = res_reg;

  // A result comes after exactly the documented sample count.
  stage_len_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R03)
    (ifc.run && ifc.sample_en && cnt_reg == limit) |=> ifc.done && cnt_reg == 10'h000)
    else $error("stage result not after full sample count");
endmodule // ccs_filter

// [rtl/ccs_if.sv]
// Purpose: Carrier between the sequencer and the decimation filter.
// Assumes: One clock domain.
// Notes:   The sequencer owns run, tick, bit and ratio; the filter answers.
`timescale 1ns/1ps
interface ccs_if;
  import ccs_pkg::*;
  logic         run;        // High while a stage converts.
  logic         sample_en;  // One-cycle modulator sample enable.
  logic         mod_bit;    // Modulator output bit.
  logic [1:0]   decim;      // Latched decimation code.
  logic         done;       // One-cycle pulse, stage result ready.
  ccs_word_type result;     // Stage result, valid with done.
  modport seq (output run, sample_en, mod_bit, decim, input done, result);
  modport filt (input run, sample_en, mod_bit, decim, output done, result);
endinterface

// [rtl/ccs_pkg.sv]
// Purpose: Types shared by the sequencer and its filter.
// Assumes: Nothing beyond the language.
// Notes:   Numbers live in ccs_defs.svh.
package ccs_pkg;
  // Sequencer states.
  typedef enum logic [1:0] {CCS_OFF, CCS_CONVERT, CCS_SLEEP} ccs_state_type;
  // One converter result word.
  typedef logic [15:0] ccs_word_type;
endpackage

// [rtl/ccs_sequencer.sv]
// Purpose: Conversion sequencer, mode control and result registers.
// Assumes: Register port and modulator bit are synchronous to CLOCK.
// Notes:   Sequence settings are sampled at each sequence start.
`timescale 1ns/1ps
`include "ccs_defs.svh"
// Notes on behaviour
// (R01) Control bits 9:8 pick ratio 256 or 128.
// (R02) Host never writes decimation codes 10 or 11.
// (R03) Each result averages three times ratio samples.
// (R04) Modulator samples at 250 kHz timing base.
// (R05) Fourteen inputs share one converter; 16-bit results.
// (R06) Two 7-bit offset codes, either input.
// (R07) At most twelve stages, each own settings.
// (R08) Sequence runs stage zero to last index.
// (R09) Host matches calibration enables to stage count.
// (R10) Differential pair: both pressed reports neither.
// (R11) Sequence time is stage time times stages.
// (R12) Low power sleep 200 to 800 ms.
// (R13) Low power period is sequence plus sleep.
// (R14) Raw result readable at address 00B.
// (R15) Per-stage results held in result bank.
// (R16) Full power runs sequences back to back.
// (R17) Mode bits: 00 full, 10 low, else off.
// (R18) Touched in low power: sequence every 36 ms.
// (R19) Setting changes apply at next sequence start.
module ccs_sequencer
  import ccs_pkg::*;
#(
  parameter int SLEEP_STEP_TICKS = `CCS_SLEEP_STEP_TICKS, // Samples per 200 ms.
  parameter int TOUCH_TICKS      = `CCS_TOUCH_TICKS,      // Samples per 36 ms.
  parameter int SAMPLE_DIV       = `CCS_SAMPLE_DIV        // Clocks per sample, 9 or more.
)(
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic [9:0]  REG_ADDR,
  input  wire logic        REG_WE,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  input  wire logic        MOD_BIT,
  input  wire logic        SENSOR_TOUCHED,
  input  wire logic        PAIR_HIT_POS,
  input  wire logic        PAIR_HIT_NEG,
  output logic      [3:0]  STAGE_INDEX,
  output logic             CONVERTING,
  output logic             SEQUENCE_DONE,
  output logic      [6:0]  POSITIVE_OFFSET_CODE,
  output logic      [6:0]  NEGATIVE_OFFSET_CODE,
  output logic             POS_OFFSET_TO_NEG,
  output logic             NEG_OFFSET_TO_POS,
  output logic             PAIR_BUTTON_POS,
  output logic             PAIR_BUTTON_NEG
);
  // ========================================================================
  // Declarations
  // ========================================================================
  ccs_if ifc ();
  ccs_state_type state_reg, state_next;        // Sequencer state.
  logic [9:0]    div_reg, div_next;            // Modulator rate divider.
  logic [3:0]    stage_reg, stage_next;        // Stage now converting.
  logic [3:0]    last_reg, last_next;          // Last stage index, latched.
  logic [1:0]    decim_reg, decim_next;        // Decimation code, latched.
  logic [1:0]    sleep_reg, sleep_next;        // Sleep select, latched.
  logic [19:0]   ticks_reg, ticks_next;        // Samples since sequence start.
  logic [19:0]   slp_reg, slp_next;            // Samples since sequence end.
  logic [15:0]   ctrl_reg, ctrl_next;          // Control register.
  logic [15:0]   offs_reg, offs_next;          // Offset codes register.
  logic [3:0]    lastw_reg, lastw_next;        // Last index as written.
  ccs_word_type  raw_reg, raw_next;            // Raw converter output.
  ccs_word_type  res_reg [`CCS_NUM_STAGES];    // Per-stage result bank.
  ccs_word_type  res_next [`CCS_NUM_STAGES];
  logic [15:0]   rdata_reg, rdata_next;        // Read data.
  logic          done_reg, done_next;          // End of sequence pulse.
  logic          bpos_reg, bneg_reg;           // Pair button outputs.
  logic          tick;                         // Modulator sample enable.
  logic [1:0]    mode;                         // Live mode field.
  logic          mode_on;                      // Mode is full or low power.
  logic          start_seq;                    // Sequence starts this cycle.
  logic [19:0]   sleep_limit;                  // Sleep length in samples.

  // ========================================================================
  // Modulator rate
  // ========================================================================
  // All conversion timing derives from this single sample enable.
  // A shorter divider only speeds simulation; the default gives the real rate.
  assign tick = (div_reg == 10'(SAMPLE_DIV - 1)); // see (R04)
  always_comb begin
    div_next = tick ? 10'h000 : div_reg + 10'h001;
  end

  // ========================================================================
  // Sequencer
  // ========================================================================
  assign mode        = ctrl_reg[`CCS_MODE_LSB +: 2];
  assign mode_on     = (mode == `CCS_MODE_FULL) || (mode == `CCS_MODE_LOW); // see (R17)
  assign sleep_limit = 20'(SLEEP_STEP_TICKS) * (20'(sleep_reg) + 20'h00001); // see (R12)

  always_comb begin
    state_next = state_reg;
    stage_next = stage_reg;
    ticks_next = (tick && state_reg != CCS_OFF) ? ticks_reg + 20'h00001 : ticks_reg; // see (R11)
    slp_next   = slp_reg;
    done_next  = 1'b0;
    raw_next   = raw_reg;
    for (int i = 0; i < `CCS_NUM_STAGES; i++) begin
      res_next[i] = res_reg[i];
    end
    start_seq = 1'b0;
    case (state_reg)
      CCS_OFF: begin
        start_seq = mode_on;
      end
      CCS_CONVERT: begin
        if (!mode_on) begin
          // Shutdown aborts at once; the filter drops its partial sum.
          state_next = CCS_OFF;
        end else if (ifc.done) begin
          raw_next = ifc.result; // see (R14)
          res_next[stage_reg] = ifc.result; // see (R15)
          if (stage_reg == last_reg) begin
            done_next = 1'b1;
            if (mode == `CCS_MODE_FULL) begin
              start_seq = 1'b1; // see (R16)
            end else begin
              state_next = CCS_SLEEP; // see (R13)
              slp_next   = 20'h00000;
            end
          end else begin
            stage_next = stage_reg + 4'h1; // see (R08)
          end
        end
      end
      CCS_SLEEP: begin
        if (!mode_on) begin
          state_next = CCS_OFF;
        end else if (tick) begin
          slp_next = slp_reg + 20'h00001;
          // Touch shortens the period to the fixed touch rate.
          if ((SENSOR_TOUCHED && ticks_reg >= 20'(TOUCH_TICKS - 1)) || // see (R18)
              (slp_reg >= sleep_limit - 20'h00001)) begin // see (R12) (R13)
            start_seq = 1'b1;
          end
        end
      end
      default: begin
        state_next = CCS_OFF;
      end
    endcase
    if (start_seq) begin
      state_next = CCS_CONVERT;
      stage_next = 4'h0; // see (R08)
      ticks_next = 20'h00000;
    end
  end

  // Settings are sampled only when a sequence starts.
  always_comb begin
    decim_next = start_seq ? ctrl_reg[`CCS_DECIM_LSB +: 2] : decim_reg; // see (R19) (R01)
    sleep_next = start_seq ? ctrl_reg[`CCS_SLEEP_LSB +: 2] : sleep_reg; // see (R19)
    last_next  = last_reg;
    if (start_seq) begin
      // Out of range indices are held at the twelve stage maximum.
      last_next = (lastw_reg > `CCS_LAST_MAX) ? `CCS_LAST_MAX : lastw_reg; // see (R07)
    end
  end

  // ========================================================================
  // Register port
  // ========================================================================
  // Writes land in one cycle; reads return one cycle after the address.
  always_comb begin
    ctrl_next  = ctrl_reg;
    offs_next  = offs_reg;
    lastw_next = lastw_reg;
    if (REG_WE) begin
      case (REG_ADDR)
        `CCS_CTRL_ADDR: ctrl_next  = REG_WDATA;
        `CCS_OFFS_ADDR: offs_next  = REG_WDATA; // see (R06)
        `CCS_LAST_ADDR: lastw_next = REG_WDATA[3:0];
        default:        ctrl_next  = ctrl_reg;
      endcase
    end
    rdata_next = 16'h0000;
    case (REG_ADDR)
      `CCS_CTRL_ADDR:   rdata_next = ctrl_reg;
      `CCS_RAW_ADDR:    rdata_next = raw_reg; // see (R14)
      `CCS_OFFS_ADDR:   rdata_next = offs_reg;
      `CCS_LAST_ADDR:   rdata_next = {12'h000, lastw_reg};
      `CCS_STATUS_ADDR: rdata_next = {10'h000, state_reg, stage_reg};
      default: begin
        if (REG_ADDR >= `CCS_RES_BASE && REG_ADDR < `CCS_RES_BASE + 10'(`CCS_NUM_STAGES)) begin
          rdata_next = res_reg[4'(REG_ADDR - `CCS_RES_BASE)]; // see (R15)
        end
      end
    endcase
  end

  // ========================================================================
  // Registers
  // ========================================================================
  always_ff @(posedge CLOCK) begin
    if (!RESET_N) begin
      state_reg <= CCS_OFF;
      div_reg   <= 10'h000;
      stage_reg <= 4'h0;
      last_reg  <= `CCS_LAST_RST;
      decim_reg <= `CCS_DECIM_256;
      sleep_reg <= 2'h0;
      ticks_reg <= 20'h00000;
      slp_reg   <= 20'h00000;
      ctrl_reg  <= `CCS_CTRL_RST; // see (R17)
      offs_reg  <= `CCS_OFFS_RST;
      lastw_reg <= `CCS_LAST_RST;
      raw_reg   <= 16'h0000;
      rdata_reg <= 16'h0000;
      done_reg  <= 1'b0;
      bpos_reg  <= 1'b0;
      bneg_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      div_reg   <= div_next;
      stage_reg <= stage_next;
      last_reg  <= last_next;
      decim_reg <= decim_next;
      sleep_reg <= sleep_next;
      ticks_reg <= ticks_next;
      slp_reg   <= slp_next;
      ctrl_reg  <= ctrl_next;
      offs_reg  <= offs_next;
      lastw_reg <= lastw_next;
      raw_reg   <= raw_next;
      rdata_reg <= rdata_next;
      done_reg  <= done_next;
      bpos_reg  <= PAIR_HIT_POS && !PAIR_HIT_NEG; // see (R10)
      bneg_reg  <= PAIR_HIT_NEG && !PAIR_HIT_POS; // see (R10)
    end
  end

  // The result bank, one register per stage.
  for (genvar g = 0; g < `CCS_NUM_STAGES; g++) begin : g_res
    always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
        res_reg[g] <= 16'h0000;
      end else begin
        res_reg[g] <= res_next[g];
      end
    end
  end

  // ========================================================================
  // Filter and outputs
  // ========================================================================
  assign ifc.run       = (state_reg == CCS_CONVERT) && mode_on;
  assign ifc.sample_en = tick;
  assign ifc.mod_bit   = MOD_BIT;
  assign ifc.decim     = decim_reg;

  ccs_filter u_filter (
    .CLOCK   (CLOCK),
    .RESET_N (RESET_N),
    .ifc     (ifc.filt)
  );

  assign REG_RDATA            = rdata_reg;
  assign STAGE_INDEX          = stage_reg;
  assign CONVERTING           = (state_reg == CCS_CONVERT);
  assign SEQUENCE_DONE        = done_reg;
  assign POSITIVE_OFFSET_CODE = offs_reg[`CCS_OPOS_LSB +: 7]; // see (R06)
  assign NEGATIVE_OFFSET_CODE = offs_reg[`CCS_ONEG_LSB +: 7];
  assign POS_OFFSET_TO_NEG    = offs_reg[`CCS_POS_SWAP_BIT];
  assign NEG_OFFSET_TO_POS    = offs_reg[`CCS_NEG_SWAP_BIT];
  assign PAIR_BUTTON_POS      = bpos_reg;
  assign PAIR_BUTTON_NEG      = bneg_reg;

  // ========================================================================
  // Checks
  // ========================================================================
  tick_spacing_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R04)
    tick |=> !tick [*8]) else $error("sample enables too close");
  stage_bound_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R07)
    (state_reg == CCS_CONVERT) |-> stage_reg <= last_reg && last_reg <= `CCS_LAST_MAX)
    else $error("stage beyond last index");
  seq_zero_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R08)
    start_seq |=> state_reg == CCS_CONVERT && stage_reg == 4'h0)
    else $error("sequence did not start at stage zero");
  full_back_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R16)
    (state_reg == CCS_CONVERT && ifc.done && stage_reg == last_reg &&
     mode == `CCS_MODE_FULL) |=> state_reg == CCS_CONVERT && ticks_reg == 20'h00000)
    else $error("full power sequence not back to back");
  low_sleep_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R13)
    (state_reg == CCS_CONVERT && ifc.done && stage_reg == last_reg &&
     mode == `CCS_MODE_LOW) |=> state_reg == CCS_SLEEP && slp_reg == 20'h00000)
    else $error("low power did not sleep");
  shut_off_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R17)
    (!mode_on && state_reg != CCS_OFF) |=> state_reg == CCS_OFF && !CONVERTING)
    else $error("shutdown not honoured");
  pair_excl_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R10)
    $past(PAIR_HIT_POS && PAIR_HIT_NEG) |-> !PAIR_BUTTON_POS && !PAIR_BUTTON_NEG)
    else $error("both pair buttons reported");
  raw_load_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R14)
    (state_reg == CCS_CONVERT && mode_on && ifc.done) |=> raw_reg == $past(ifc.result))
    else $error("raw result not loaded");
  setting_hold_a: assert property (@(posedge CLOCK) disable iff (!RESET_N) // see (R19)
    (state_reg == CCS_CONVERT && !start_seq) |=> $stable(decim_reg) && $stable(last_reg))
    else $error("settings changed inside a sequence");
endmodule // ccs_sequencer

// [verif/cap_conversion_sequencer_tb.sv]
// Purpose: Self-checking bench for the conversion sequencer.
// Assumes: The sample divider is shortened so whole sequences fit the run.
// Notes:   Covers registers, offsets, pair logic, modes, results and sleep.
`timescale 1ns/1ps
`include "ccs_defs.svh"
module cap_conversion_sequencer_tb;
  import ccs_pkg::*;
  // ========================================================================
  // Signals
  // ========================================================================
  logic        clock = 1'b0;     // 200 MHz clock.
  logic        reset_n = 1'b0;   // Active-low reset.
  logic [9:0]  reg_addr = 10'h000; // Register address.
  logic        reg_we = 1'b0;    // Write strobe.
  logic [15:0] reg_wdata = 16'h0000; // Write data.
  logic [15:0] reg_rdata;        // Read data.
  logic        mod_bit, touched, touch = 1'b0, ones = 1'b0; // Sensor side.
  logic        hit_pos = 1'b0, hit_neg = 1'b0; // Raw pair hits.
  logic [3:0]  stage_index;      // Current stage.
  logic        converting, sequence_done, pos_to_neg, neg_to_pos, btn_pos, btn_neg;
  logic [6:0]  pos_code, neg_code; // Offset codes.
  int          num_errors = 0;   // Mismatch count.
  int          comparisons = 0;  // Compare count.
  int          seed = 47814;     // Fixed seed keeps runs repeatable.

  always #2.5 clock = ~clock;

  ccs_sequencer #(.SLEEP_STEP_TICKS(20), .TOUCH_TICKS(8), .SAMPLE_DIV(10)) i_dut (
    .CLOCK(clock), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WE(reg_we),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .MOD_BIT(mod_bit),
    .SENSOR_TOUCHED(touched), .PAIR_HIT_POS(hit_pos), .PAIR_HIT_NEG(hit_neg),
    .STAGE_INDEX(stage_index), .CONVERTING(converting), .SEQUENCE_DONE(sequence_done),
    .POSITIVE_OFFSET_CODE(pos_code), .NEGATIVE_OFFSET_CODE(neg_code),
    .POS_OFFSET_TO_NEG(pos_to_neg), .NEG_OFFSET_TO_POS(neg_to_pos),
    .PAIR_BUTTON_POS(btn_pos), .PAIR_BUTTON_NEG(btn_neg));

  ccs_sensor_model i_model (.CLOCK(clock), .STAGE_INDEX(stage_index), .TOUCH(touch),
    .ALL_ONES(ones), .MOD_BIT(mod_bit), .SENSOR_TOUCHED(touched));

  // ========================================================================
  // Tasks and expectation functions
  // ========================================================================
  // Both pressed together must report neither button.
  function automatic logic [1:0] pair_exp(input logic p, input logic n);
    return {p & ~n, n & ~p};
  endfunction

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Write, then idle one cycle so the strobe never toggles twice at once.
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clock);
    reg_we = 1'b0;
    @(negedge clock);
  endtask

  // Read data is registered, so it is taken one cycle after the address.
  task automatic rd(input logic [9:0] a, output logic [15:0] d);
    reg_addr = a;
    @(negedge clock);
    d = reg_rdata;
  endtask

  // Bounded wait on the converting level; a spent bound ends the run.
  task automatic wait_conv(input logic lvl, input int lim, output int n);
    n = 0;
    while (converting !== lvl && n < lim) begin
      @(negedge clock);
      n++;
    end
    check("converting", {15'h0, lvl}, {15'h0, converting});
    if (converting !== lvl) finish_test();
  endtask

  // Bounded wait on the end of sequence pulse; returns the cycles waited.
  task automatic wait_done(output int n);
    n = 0;
    while (sequence_done !== 1'b1 && n < 9000) begin
      @(negedge clock);
      n++;
    end
    if (sequence_done !== 1'b1) begin
      check("sequence_done", 16'h1, {15'h0, sequence_done});
      finish_test();
    end
  endtask

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    logic [15:0] d, v;
    int          n;
    repeat (16) @(negedge clock);
    check("converting_in_reset", 16'h0, {15'h0, converting});
    reset_n = 1'b1;
    wait_conv(1'b1, 8, n);
    check("stage_index", 16'h0, {12'h0, stage_index});
    rd(`CCS_CTRL_ADDR, d);
    check("ctrl", `CCS_CTRL_RST, d);
    rd(`CCS_LAST_ADDR, d);
    check("last", {12'h0, `CCS_LAST_RST}, d);
    wr(`CCS_RAW_ADDR, 16'hFFFF);
    rd(`CCS_RAW_ADDR, d);
    check("raw", 16'h0000, d);
    rd(`CCS_RES_BASE + 10'h00B, d);
    check("bank", 16'h0000, d);
    rd(10'h3FF, d);
    check("unmapped", 16'h0000, d);
    $display("test registers done");
    // Offset codes, with the all-ones and all-zero corners first.
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'($random(seed));
      wr(`CCS_OFFS_ADDR, v);
      check("pos_code", {9'h0, v[6:0]}, {9'h0, pos_code});
      check("neg_code", {9'h0, v[14:8]}, {9'h0, neg_code});
      check("swaps", {14'h0, v[15], v[7]}, {14'h0, neg_to_pos, pos_to_neg});
    end
    $display("test offsets done");
    // Every hit combination, then random ones with touch toggling.
    for (int i = 0; i < 12; i++) begin
      v = 16'($random(seed));
      {hit_pos, hit_neg} = (i < 4) ? 2'(i) : v[1:0];
      touch = v[2];
      @(negedge clock);
      check("pair", {14'h0, pair_exp(hit_pos, hit_neg)}, {14'h0, btn_pos, btn_neg});
    end
    $display("test pair done");
    // Legal settings only; codes 10 and 11 are never programmed.
    v = {6'h0, 1'b0, v[8], 4'h0, v[3:2], 2'h0};
    wr(`CCS_CTRL_ADDR, v);
    rd(`CCS_CTRL_ADDR, d);
    check("ctrl", v, d);
    wr(`CCS_LAST_ADDR, 16'h0005);
    rd(`CCS_LAST_ADDR, d);
    check("last", 16'h0005, d);
    // Both shutdown codes stop at once; full power restarts from stage zero.
    for (int i = 1; i < 4; i += 2) begin
      wr(`CCS_CTRL_ADDR, 16'(i));
      wait_conv(1'b0, 8, n);
      rd(`CCS_STATUS_ADDR, d);
      check("status", 16'h0000, d);
      wr(`CCS_CTRL_ADDR, 16'h0000);
      wait_conv(1'b1, 8, n);
      check("stage_index", 16'h0, {12'h0, stage_index});
    end
    // Low power is only applied at sequence end, so conversion goes on.
    wr(`CCS_CTRL_ADDR, 16'h0002);
    repeat (4) @(negedge clock);
    check("converting_low", 16'h1, {15'h0, converting});
    $display("test modes done");
    // Two stages at ratio 128 on a full-scale input, low power, sleep 400 ms.
    // A sequence is 2 x 384 samples of 10 clocks; a sleep is 40 samples.
    wr(`CCS_CTRL_ADDR, 16'h0001);
    wait_conv(1'b0, 8, n);
    wr(`CCS_LAST_ADDR, 16'h0001);
    ones = 1'b1;
    wr(`CCS_CTRL_ADDR, 16'h0106);
    wait_conv(1'b1, 8, n);
    for (int k = 0; k < 2; k++) begin
      // The second pass is touched, so the sleep is cut short.
      touch = (k == 1);
      wait_done(n);
      check("seq_cycles", 16'h1, {15'h0, n > 7669 && n < 7691});
      check("last_stage", 16'h1, {12'h0, stage_index});
      rd(`CCS_RAW_ADDR, d);
      check("raw_full", 16'(`CCS_LEN_128 * `CCS_GAIN_128), d);
      rd(`CCS_RES_BASE + 10'(k), d);
      check("bank_full", 16'(`CCS_LEN_128 * `CCS_GAIN_128), d);
      check("conv_sleep", 16'h0, {15'h0, converting});
      wait_conv(1'b1, 600, n);
      check("wake_cycles", 16'h1, {15'h0, (k == 0) ? (n > 387 && n < 407) : (n < 12)});
    end
    $display("test conversion done");
    finish_test();
  end
endmodule // cap_conversion_sequencer_tb

// [verif/ccs_sensor_model.sv]
// Purpose: Behavioural sensor and modulator seen behind the converter input.
// Assumes: Driven off the falling edge, as all bench stimulus is.
// Notes:   The bit stream is pseudo-random, so no stage sees a constant input unless ALL_ONES forces a full-scale one.
`timescale 1ns/1ps
module ccs_sensor_model (
  input  wire logic       CLOCK,
  input  wire logic [3:0] STAGE_INDEX,
  input  wire logic       TOUCH,
  input  wire logic       ALL_ONES,
  output logic            MOD_BIT,
  output logic            SENSOR_TOUCHED
);
  // ========================================================================
  // Modulator stream
  // ========================================================================
  logic [15:0] lfsr_reg = 16'hACE1; // Stream state, never all zero.

  // A new bit every cycle, so a stuck sampler shows up in the result.
  always @(negedge CLOCK) begin
    lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end

  // Each stage reaches a different electrode, so the stream depends on it.
  // A full-scale input makes every sample a one, so the result is known.
  assign MOD_BIT        = ALL_ONES | (lfsr_reg[0] ^ STAGE_INDEX[0]);
  assign SENSOR_TOUCHED = TOUCH;                         // Touch level from the bench.
endmodule // ccs_sensor_model
